// >>> logic/carrier_pwr_ctl.sv
// carrier-side power logic: request release, rail follow, pl switch
`timescale 1ns/10ps
module carrier_pwr_ctl
  import pwr_seq_pkg::*;
(
  // clock and reset
  input  wire logic      CORE_CLK_I,
  input  wire logic      SYS_RST_I,
  // module link
  pwr_seq_if.carrier_end LINK,
  // user side
  input  wire logic      SUPPLY_GOOD_I,
  input  wire logic      PL_ON_REQ_I,
  input  wire logic      PL_OFF_REQ_I,
  output logic           PS_SUPPLY_ON_O,
  output logic           PL_SUPPLY_ON_O,
  output logic [7:0]     PL_STATE_O
);
  logic       req_n_q;
  logic       wr_q;
  logic [7:0] wdata_q;
  logic       ps_on_q;
  logic       pl_on_q;
  logic [7:0] rd_q;

  //////////////////////////////////////////////////////////////////////////
  // power-off request held until supply good
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      req_n_q <= 1'b0;
    end else begin
      req_n_q <= SUPPLY_GOOD_I; // see RULE1
    end
  end
  assign LINK.power_off_request_n = req_n_q;

  //////////////////////////////////////////////////////////////////////////
  // pl power state writes, on wins
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      wr_q    <= 1'b0;
      wdata_q <= PL_PWR_OFF_VAL;
    end else begin
      wr_q <= PL_ON_REQ_I || PL_OFF_REQ_I;
      if (PL_ON_REQ_I) begin
        wdata_q <= PL_PWR_ON_VAL; // see RULE6
      end else if (PL_OFF_REQ_I) begin
        wdata_q <= PL_PWR_OFF_VAL; // see RULE6
      end
    end
  end
  assign LINK.reg_wr    = wr_q;
  assign LINK.reg_addr  = PL_PWR_STATE_ADDR; // see RULE6
  assign LINK.reg_wdata = wdata_q;

  //////////////////////////////////////////////////////////////////////////
  // supplies follow the module enables
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ps_on_q <= 1'b0;
      pl_on_q <= 1'b0;
      rd_q    <= '0;
    end else begin
      ps_on_q <= LINK.ps_io_rail_enable;                           // see RULE3
      pl_on_q <= LINK.pl_io_rail_enable && LINK.ps_io_rail_enable; // see RULE4
      rd_q    <= LINK.reg_rdata;
    end
  end
  assign PS_SUPPLY_ON_O = ps_on_q;
  assign PL_SUPPLY_ON_O = pl_on_q;
  assign PL_STATE_O     = rd_q;
endmodule

// >>> logic/module_pwr_seq.sv
// module-side power sequencer with shutdown edge detection
`timescale 1ns/10ps
module module_pwr_seq
  import pwr_seq_pkg::*;
(
  // clock and reset
  input  wire logic       CORE_CLK_I,
  input  wire logic       SYS_RST_I,
  // carrier link
  pwr_seq_if.module_end   LINK,
  // management processor shutdown pin (three signals)
  input  wire logic       SHDN_PIN_I,
  output logic            SHDN_PIN_O,
  output logic            SHDN_PIN_OE_O,
  // management output register write and software shutdown use
  input  wire logic       MGMT_WR_I,
  input  wire logic [7:0] MGMT_WDATA_I,
  input  wire logic       SW_SHDN_USED_I,
  // status
  output logic            POR_DONE_O,
  output logic            CORE_RAILS_UP_O,
  output logic [7:0]      MGMT_OUT_O
);
  typedef enum logic [4:0] {
    ST_OFF  = 5'b00001,
    ST_CORE = 5'b00010,
    ST_PS   = 5'b00100,
    ST_ON   = 5'b01000,
    ST_DOWN = 5'b10000
  } seq_t;

  seq_t             state_q;
  logic [CNT_W-1:0] step_q;
  logic [CNT_W-1:0] por_q;
  logic             por_done_q;
  logic             pin_q;
  logic             shdn_fall;
  logic [7:0]       pl_state_q;
  logic [7:0]       mgmt_q;
  logic             ps_en_q;
  logic             pl_en_q;
  logic             step_done;
  logic             down_done_q;
  logic             force_off;
  logic             shdn_start;
  logic             seq_restart;
  logic             ps_en_d;
  logic             pl_en_d;

  assign step_done = (step_q == CNT_W'(RAIL_STEP_CYC - 1));

  //////////////////////////////////////////////////////////////////////////
  // management output register, shutdown pin drive
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      mgmt_q <= MGMT_OUT_RESET; // see RULE10
    end else if (MGMT_WR_I) begin
      mgmt_q <= MGMT_WDATA_I;
    end
  end
  assign SHDN_PIN_O    = mgmt_q[SHDN_BIT]; // see RULE9
  assign SHDN_PIN_OE_O = SW_SHDN_USED_I;   // see RULE11
  assign MGMT_OUT_O    = mgmt_q;

  //////////////////////////////////////////////////////////////////////////
  // power-on reset timer, starts with the internal sequence
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      por_q      <= '0;
      por_done_q <= 1'b0;
    end else if (state_q == ST_OFF) begin
      por_q      <= '0;
      por_done_q <= 1'b0;
    end else if (!por_done_q) begin
      por_q      <= por_q + 1'b1;
      por_done_q <= (por_q == CNT_W'(POR_CYC - 1));
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // shutdown edge detector, blind until the power-on reset timer is done
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= SHDN_PIN_I;
    end
  end
  assign shdn_fall = por_done_q && pin_q && !SHDN_PIN_I; // see RULE7, RULE8

  //////////////////////////////////////////////////////////////////////////
  // sequence restarts: power-off request or accepted shutdown edge
  assign force_off   = !LINK.power_off_request_n && (state_q != ST_DOWN);
  assign shdn_start  = shdn_fall && (state_q != ST_DOWN);
  assign seq_restart = force_off || shdn_start;

  //////////////////////////////////////////////////////////////////////////
  // step counter, runs in the timed states only
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      step_q <= '0;
    end else if (seq_restart || step_done) begin
      step_q <= '0;
    end else if ((state_q == ST_OFF) || (state_q == ST_ON)) begin
      step_q <= '0;
    end else begin
      step_q <= step_q + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // shutdown step complete, kept so a late power-off request still lands
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      down_done_q <= 1'b0;
    end else if (state_q != ST_DOWN) begin
      down_done_q <= 1'b0;
    end else if (step_done) begin
      down_done_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state_q <= ST_OFF;
    end else if (force_off) begin
      state_q <= ST_OFF; // see RULE13
    end else if (shdn_start) begin
      state_q <= ST_DOWN; // see RULE7
    end else begin
      unique case (state_q)
        ST_OFF: begin
          state_q <= ST_CORE; // see RULE2
        end
        ST_CORE: begin
          if (step_done && por_done_q) begin
            state_q <= ST_PS;
          end
        end
        ST_PS: begin
          if (step_done) begin
            state_q <= ST_ON;
          end
        end
        ST_ON: begin
          state_q <= ST_ON;
        end
        ST_DOWN: begin
          if ((step_done || down_done_q) && !LINK.power_off_request_n) begin
            state_q <= ST_OFF; // see RULE13
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // rail enable levels per state
  always_comb begin
    ps_en_d = 1'b0;
    pl_en_d = 1'b0;
    unique case (state_q)
      ST_OFF, ST_CORE, ST_DOWN: begin
        ps_en_d = 1'b0;
        pl_en_d = 1'b0;
      end
      ST_PS: begin
        ps_en_d = 1'b1; // see RULE3
      end
      ST_ON: begin
        ps_en_d = 1'b1; // see RULE3
        pl_en_d = 1'b1; // see RULE4
      end
    endcase
  end

  // rail enables, registered push-pull levels
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ps_en_q <= 1'b0;
      pl_en_q <= 1'b0;
    end else begin
      ps_en_q <= ps_en_d;
      pl_en_q <= pl_en_d;
    end
  end
  assign LINK.ps_io_rail_enable = ps_en_q; // see RULE12
  assign LINK.pl_io_rail_enable = pl_en_q; // see RULE12

  //////////////////////////////////////////////////////////////////////////
  // pl power state register in the monitor
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pl_state_q <= PL_PWR_RESET_VAL;
    end else if (LINK.reg_wr && LINK.reg_addr == PL_PWR_STATE_ADDR) begin
      pl_state_q <= LINK.reg_wdata; // see RULE5
    end
  end
  assign LINK.reg_rdata = (LINK.reg_addr == PL_PWR_STATE_ADDR) ?
                          pl_state_q : 8'h00;
  assign LINK.pl_domain_good = (pl_state_q == PL_PWR_ON_VAL) &&
                               (state_q == ST_ON); // see RULE5

  assign POR_DONE_O      = por_done_q;
  assign CORE_RAILS_UP_O = (state_q != ST_OFF) && (state_q != ST_DOWN);
endmodule

// >>> logic/pwr_seq_if.sv
// link between module sequencer and carrier power logic
`timescale 1ns/10ps
interface pwr_seq_if;
  logic       power_off_request_n;
  logic       ps_io_rail_enable;
  logic       pl_io_rail_enable;
  logic       pl_domain_good;
  logic       reg_wr;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  modport module_end (
    input  power_off_request_n, reg_wr, reg_addr, reg_wdata,
    output ps_io_rail_enable, pl_io_rail_enable, pl_domain_good, reg_rdata
  );
  modport carrier_end (
    output power_off_request_n, reg_wr, reg_addr, reg_wdata,
    input  ps_io_rail_enable, pl_io_rail_enable, pl_domain_good, reg_rdata
  );
endinterface

// >>> logic/pwr_seq_pkg.sv
// shared constants for the module power sequencer and carrier logic
// Notes on behaviour
// RULE1: carrier holds power-off request until supply good
// RULE2: internal rail sequence starts before any enable
// RULE3: module asserts ps enable, carrier powers ps
// RULE4: pl enable follows ps, carrier powers pl
// RULE5: pl domain switched by monitor state register
// RULE6: write 0x3E to 0x08 on, 0x00 off
// RULE7: falling shutdown edge sequences all supplies down
// RULE8: shutdown ignored until power-on reset released
// RULE9: shutdown pin driven from output bit two
// RULE10: shutdown output bit defaults to zero
// RULE11: unused shutdown pin tri-stated, pulled high
// RULE12: rail enables active high, push-pull
// RULE13: enables low during power-off or shutdown
package pwr_seq_pkg;
  // monitor register map
  localparam logic [7:0] PL_PWR_STATE_ADDR = 8'h08;
  localparam logic [7:0] PL_PWR_OFF_VAL    = 8'h00;
  localparam logic [7:0] PL_PWR_ON_VAL     = 8'h3E;
  localparam logic [7:0] PL_PWR_RESET_VAL  = 8'h3E;
  // shutdown drive bit in management output register
  localparam int         SHDN_BIT          = 2;
  localparam logic [7:0] MGMT_OUT_RESET    = 8'h00;
  // sequencing step times
  localparam int         CLK_MHZ           = 100;
  localparam int         RAIL_STEP_US      = 10;
  localparam int         RAIL_STEP_CYC     = RAIL_STEP_US * CLK_MHZ;
  localparam int         POR_US            = 20;
  localparam int         POR_CYC           = POR_US * CLK_MHZ;
  localparam int         CNT_W             = 12;
endpackage

// >>> sim/pwr_seq_props.sv
// assertions on the sequencer to carrier link
`timescale 1ns/10ps
module pwr_seq_props (
  // clock and reset
  input wire logic       CORE_CLK_I,
  input wire logic       SYS_RST_I,
  // link signals
  input wire logic       power_off_request_n,
  input wire logic       ps_io_rail_enable,
  input wire logic       pl_io_rail_enable,
  input wire logic       pl_domain_good,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  logic [15:0] up_q;
  logic [15:0] ps_q;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  ////////////////////////////////////////////////////////////////////////////
  // cycles since request release and since ps enable
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      up_q <= 16'h0000;
      ps_q <= 16'h0000;
    end else begin
      up_q <= power_off_request_n ? up_q + 16'h0001 : 16'h0000;
      ps_q <= ps_io_rail_enable ? ps_q + 16'h0001 : 16'h0000;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_pl_after_ps: assert property (
    pl_io_rail_enable |-> ps_io_rail_enable) else $error("pl before ps");
  a_ps_waits_por: assert property (
    $rose(ps_io_rail_enable) |-> up_q >= 16'h07D0 && !pl_io_rail_enable)
    else $error("ps enable too early");
  a_pl_step_gap: assert property (
    $rose(pl_io_rail_enable) |-> ps_q inside {[16'h03E6:16'h03EA]})
    else $error("pl enable gap wrong");
  a_off_clears_en: assert property (
    !power_off_request_n |-> ##2 !ps_io_rail_enable && !pl_io_rail_enable)
    else $error("enables up during power-off");
  a_off_drops_good: assert property (
    !power_off_request_n |-> ##2 !pl_domain_good) else $error("good held");
  a_state_write: assert property (
    reg_wr && reg_addr == 8'h08 |=> reg_rdata == $past(reg_wdata))
    else $error("state register not written");
  a_good_on_val: assert property (
    pl_domain_good |-> reg_rdata == 8'h3E) else $error("good without on");
  a_off_val_drop: assert property (
    reg_wr && reg_wdata == 8'h00 |=> !pl_domain_good)
    else $error("pl domain still good");
endmodule

// >>> sim/test_module_power_sequencing.sv
// bench for sequencer and carrier power logic
`timescale 1ns/10ps
module test_module_power_sequencing;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       sup = 1'b0;
  logic       on_rq = 1'b0;
  logic       off_rq = 1'b0;
  logic       m_wr = 1'b0;
  logic [7:0] m_wd = 8'h00;
  logic       sw = 1'b0;
  logic       s_o;
  logic       s_oe;
  logic       por;
  logic [7:0] m_out;
  logic       ps_on;
  logic       pl_on;
  logic [7:0] pl_st;
  logic       up;
  int         error_cnt = 0;
  int         checks = 0;
  wire        s_w = s_oe ? s_o : 1'b1;
  pwr_seq_if  i_pwr_seq_if ();
  wire        ps = i_pwr_seq_if.ps_io_rail_enable;
  wire        pl = i_pwr_seq_if.pl_io_rail_enable;
  always #5 clk = ~clk;
  module_pwr_seq i_module_pwr_seq (.CORE_CLK_I(clk), .SYS_RST_I(rst),
    .LINK(i_pwr_seq_if.module_end), .SHDN_PIN_I(s_w), .SHDN_PIN_O(s_o),
    .SHDN_PIN_OE_O(s_oe), .MGMT_WR_I(m_wr), .MGMT_WDATA_I(m_wd),
    .SW_SHDN_USED_I(sw), .POR_DONE_O(por), .CORE_RAILS_UP_O(up),
    .MGMT_OUT_O(m_out));
  carrier_pwr_ctl i_carrier_pwr_ctl (.CORE_CLK_I(clk), .SYS_RST_I(rst),
    .LINK(i_pwr_seq_if.carrier_end), .SUPPLY_GOOD_I(sup),
    .PL_ON_REQ_I(on_rq), .PL_OFF_REQ_I(off_rq), .PS_SUPPLY_ON_O(ps_on),
    .PL_SUPPLY_ON_O(pl_on), .PL_STATE_O(pl_st));
  pwr_seq_props i_pwr_seq_props (.CORE_CLK_I(clk), .SYS_RST_I(rst),
    .power_off_request_n(i_pwr_seq_if.power_off_request_n),
    .ps_io_rail_enable(ps), .pl_io_rail_enable(pl),
    .pl_domain_good(i_pwr_seq_if.pl_domain_good),
    .reg_wr(i_pwr_seq_if.reg_wr), .reg_addr(i_pwr_seq_if.reg_addr),
    .reg_wdata(i_pwr_seq_if.reg_wdata), .reg_rdata(i_pwr_seq_if.reg_rdata));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic mgmt(input logic [7:0] d);
    m_wr = 1'b1;
    m_wd = d;
    cyc(1);
    m_wr = 1'b0;
    cyc(1);
  endtask
  task automatic pl_req(input logic on);
    on_rq = on;
    off_rq = !on;
    cyc(1);
    on_rq = 1'b0;
    off_rq = 1'b0;
    cyc(4);
  endtask
  task automatic wait_en(input logic sel, input int lim);
    int n = 0;
    while (n < lim && (sel ? pl : ps) !== 1'b1) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(5);
    rst = 1'b0;
    chk(i_pwr_seq_if.power_off_request_n, 8'h00);
    chk({s_oe, s_w}, 8'h01);
    chk(m_out, 8'h00);
    $display("test reset done");
    sup = 1'b1;
    sw = 1'b1;
    cyc(3);
    chk(i_pwr_seq_if.power_off_request_n, 8'h01);
    mgmt(8'h04);
    chk(s_o, 8'h01);
    mgmt(8'h00);
    chk(por, 8'h00);
    wait_en(1'b0, 3100);
    chk({ps, pl}, 8'h02);
    chk({por, up}, 8'h03);
    wait_en(1'b1, 1010);
    cyc(2);
    chk({ps, pl, ps_on, pl_on}, 8'h0F);
    $display("test power up done");
    pl_req(1'b0);
    chk(pl_st, 8'h00);
    chk(i_pwr_seq_if.pl_domain_good, 8'h00);
    pl_req(1'b1);
    chk(pl_st, 8'h3E);
    chk(i_pwr_seq_if.pl_domain_good, 8'h01);
    $display("test pl switch done");
    mgmt(8'h04);
    mgmt(8'h00);
    cyc(3);
    chk({ps, pl}, 8'h00);
    cyc(1100);
    chk({ps, pl}, 8'h00);
    chk(up, 8'h00);
    $display("test shutdown done");
    sup = 1'b0;
    cyc(3);
    sup = 1'b1;
    wait_en(1'b0, 3100);
    chk(ps, 8'h01);
    sup = 1'b0;
    cyc(4);
    chk({ps, pl}, 8'h00);
    $display("test power off done");
    end_of_test();
  end
  initial begin
    #200_000;
    error_cnt++;
    end_of_test();
  end
endmodule
